//--- src/sed_consts.svh
// Constants of the serial EEPROM instruction decoder: opcodes, status bits,
// address fields and protection bounds. Included by the decoder file only.
`ifndef SED_CONSTS_SVH
`define SED_CONSTS_SVH

`define SED_OP_SET_WE   8'h06
`define SED_OP_CLR_WE   8'h04
`define SED_OP_STAT_RD  8'h05
`define SED_OP_STAT_WR  8'h01
`define SED_OP_ARR_RD   8'h03
`define SED_OP_ARR_WR   8'h02
`define SED_OP_ID_RD    8'h83
`define SED_OP_ID_WR    8'h82

`define SED_BIT_LAST    3'h7
`define SED_ADDR_LAST   2'h2
`define SED_SEL_BIT     10
`define SED_ARR_MSB     18
`define SED_ID_MSB      8
`define SED_ARR_PAD     5'h00
`define SED_ID_PAD      15'h0000

`define SED_NV_RESET    3'h0
`define SED_NV_SWD      2
`define SED_BP_NONE     2'h0
`define SED_BP_QUARTER  2'h1
`define SED_BP_HALF     2'h2
`define SED_QTR_BASE    19'h60000
`define SED_HALF_BASE   19'h40000
`define SED_SR_ZERO     3'h0

`endif

//--- src/sed_pkg.sv
// Types shared by the instruction decoder files.
// Assumes the constants header is compiled alongside.
package sed_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS, ST_WAIT
  } sed_state_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_SET_WE, CMD_CLR_WE, CMD_STAT_RD, CMD_STAT_WR,
    CMD_ARR_RD, CMD_ARR_WR, CMD_ID_RD, CMD_ID_WR, CMD_LOCK_RD, CMD_LOCK
  } sed_cmd_t;

endpackage : sed_pkg

//--- src/sed_stream_if.sv
// Byte stream between the decoder and its write-data buffer.
// Assumes both ends run on the decoder clock.
`timescale 1ns/100ps
`default_nettype none

interface sed_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sed_stream_if

`default_nettype wire

//--- src/sed_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk; reset value is a constant.
`timescale 1ns/100ps
`default_nettype none

module sed_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sed_sync

`default_nettype wire

//--- src/sed_fifo2.sv
// Two-entry buffer for received write-data bytes.
// Assumes the sink may stall; ready drops only when both entries are held.
`timescale 1ns/100ps
`default_nettype none

module sed_fifo2 (
  input  wire logic   clk,
  input  wire logic   rst_n,
  sed_stream_if.snk   in_if,
  output logic        out_valid,
  input  wire logic   out_ready,
  output logic [7:0]  out_data
);
  logic [7:0] mem_r [2];
  logic       wptr_r;
  logic       rptr_r;
  logic [1:0] cnt_r;
  wire        push = in_if.valid & in_if.ready;
  wire        pop  = out_valid & out_ready;

  assign in_if.ready = (cnt_r != 2'h2);
  assign out_valid   = (cnt_r != 2'h0);
  assign out_data    = mem_r[rptr_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wptr_r   <= 1'b0;
      rptr_r   <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wptr_r] <= in_if.data;
        wptr_r        <= ~wptr_r;
      end
      if (pop) rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : sed_fifo2

`default_nettype wire

//--- src/sed_decoder.sv
// Instruction decoder and status/protection logic of a serial EEPROM.
// Assumes pins arrive asynchronously and are oversampled by clk; the memory
// core performs the self-timed write and array reads and answers wr_done.
`timescale 1ns/100ps
`default_nettype none
`include "sed_consts.svh"

module sed_decoder (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe,
  output logic                   rd_req,
  output sed_pkg::sed_cmd_t      rd_kind,
  output logic [23:0]            rd_addr,
  output logic                   wr_start,
  output sed_pkg::sed_cmd_t      wr_kind,
  output logic [23:0]            wr_addr,
  output logic                   wr_abort,
  input  wire logic              wr_done,
  output logic                   wd_valid,
  input  wire logic              wd_ready,
  output logic [7:0]             wd_data,
  output logic [7:0]             status_byte,
  output logic                   hw_protected,
  output logic                   rx_overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic [1:0] rst_sh_r;
  wire        rst_ok_n = rst_sh_r[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sh_r <= 2'b00;
    else        rst_sh_r <= {rst_sh_r[0], 1'b1};
  end

  logic cs_s;
  logic sck_s;
  logic si_s;
  logic wp_s;

  sed_sync #(.W(4), .INIT(4'h9)) u_sync (
    .clk   (clk),
    .rst_n (rst_ok_n),
    .d     ({cs_n, sck, si, wp_n}),
    .q     ({cs_s, sck_s, si_s, wp_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic sed_pkg::sed_cmd_t dec_op(input logic [7:0] b);
    if      (b == `SED_OP_SET_WE)  dec_op = sed_pkg::CMD_SET_WE;
    else if (b == `SED_OP_CLR_WE)  dec_op = sed_pkg::CMD_CLR_WE;
    else if (b == `SED_OP_STAT_RD) dec_op = sed_pkg::CMD_STAT_RD;
    else if (b == `SED_OP_STAT_WR) dec_op = sed_pkg::CMD_STAT_WR;
    else if (b == `SED_OP_ARR_RD)  dec_op = sed_pkg::CMD_ARR_RD;
    else if (b == `SED_OP_ARR_WR)  dec_op = sed_pkg::CMD_ARR_WR;
    else if (b == `SED_OP_ID_RD)   dec_op = sed_pkg::CMD_ID_RD;
    else if (b == `SED_OP_ID_WR)   dec_op = sed_pkg::CMD_ID_WR;
    else                           dec_op = sed_pkg::CMD_NONE;
  endfunction : dec_op

  // Keeps only the address bits that the command uses.
  function automatic logic [23:0] mask_addr(input sed_pkg::sed_cmd_t k,
                                            input logic [23:0] a);
    if (k == sed_pkg::CMD_ARR_RD || k == sed_pkg::CMD_ARR_WR)
      mask_addr = {`SED_ARR_PAD, a[`SED_ARR_MSB:0]};
    else
      mask_addr = {`SED_ID_PAD, a[`SED_ID_MSB:0]};
  endfunction : mask_addr

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and frame tracking.

  logic sck_q;
  logic cs_q;
  logic armed_r;
  logic selected_r;

  wire sck_rise = sck_s & ~sck_q;
  wire sck_fall = ~sck_s & sck_q;
  wire cs_fall  = ~cs_s & cs_q & armed_r;
  wire cs_rise  = cs_s & ~cs_q & selected_r;

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sck_q      <= 1'b0;
      cs_q       <= 1'b1;
      armed_r    <= 1'b0;
      selected_r <= 1'b0;
    end else begin
      sck_q      <= sck_s;
      cs_q       <= cs_s;
      // Select needs a high level seen first, but the synchroniser resets cs_s high,
      // so a low pin at power-up can still start a frame.
      if (cs_s) armed_r <= 1'b1;
      if (cs_fall)      selected_r <= 1'b1;
      else if (cs_rise) selected_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial input shifting.

  sed_pkg::sed_state_t state_r;
  sed_pkg::sed_state_t state_nxt;
  sed_pkg::sed_cmd_t   cmd_r;
  logic [6:0]          shift_r;
  logic [2:0]          bit_cnt_r;
  logic [1:0]          byte_cnt_r;
  logic [23:0]         addr_r;
  logic                boundary_r;
  logic                late_r;
  logic                data_seen_r;
  logic                pushed_r;
  logic [2:0]          sr_new_r;
  logic                wel_r;
  logic                wip_r;
  logic [2:0]          nv_r;
  sed_pkg::sed_cmd_t   run_kind_r;

  wire       live     = selected_r & ~cs_rise;
  wire       rise_in  = sck_rise & live;
  wire [7:0] byte_in  = {shift_r, si_s};
  wire       byte_end = rise_in & (bit_cnt_r == `SED_BIT_LAST);
  wire [23:0] addr_in = {addr_r[15:0], byte_in};

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  wire sed_pkg::sed_cmd_t op_cmd = dec_op(byte_in);
  // During a write cycle only the status read is decoded.
  wire op_drop = (op_cmd == sed_pkg::CMD_NONE) |
                 (wip_r & (op_cmd != sed_pkg::CMD_STAT_RD));
  wire op_latch = (op_cmd == sed_pkg::CMD_SET_WE) |
                  (op_cmd == sed_pkg::CMD_CLR_WE);

  wire sed_pkg::sed_state_t op_state =
    op_drop                              ? sed_pkg::ST_WAIT   :
    op_latch                             ? sed_pkg::ST_WAIT   :
    (op_cmd == sed_pkg::CMD_STAT_RD)     ? sed_pkg::ST_STATUS :
    (op_cmd == sed_pkg::CMD_STAT_WR)     ? sed_pkg::ST_DATA   :
                                           sed_pkg::ST_ADDR;

  // Opcodes 83h/82h are resolved by address bit 10.
  wire sel_lock = addr_in[`SED_SEL_BIT];
  wire sed_pkg::sed_cmd_t addr_cmd =
    (cmd_r == sed_pkg::CMD_ID_RD && sel_lock) ? sed_pkg::CMD_LOCK_RD :
    (cmd_r == sed_pkg::CMD_ID_WR && sel_lock) ? sed_pkg::CMD_LOCK    :
                                                cmd_r;
  wire addr_is_rd = (addr_cmd == sed_pkg::CMD_ARR_RD) |
                    (addr_cmd == sed_pkg::CMD_ID_RD)  |
                    (addr_cmd == sed_pkg::CMD_LOCK_RD);
  wire addr_last  = byte_end & (state_r == sed_pkg::ST_ADDR) &
                    (byte_cnt_r == `SED_ADDR_LAST);

  always_comb begin
    state_nxt = state_r;
    if (cs_rise) begin
      state_nxt = sed_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_nxt = sed_pkg::ST_OPCODE;
    end else if (byte_end) begin
      case (state_r)
        sed_pkg::ST_OPCODE: state_nxt = op_state;
        sed_pkg::ST_ADDR: begin
          if (byte_cnt_r == `SED_ADDR_LAST)
            state_nxt = addr_is_rd ? sed_pkg::ST_WAIT : sed_pkg::ST_DATA;
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection.

  wire [1:0] bp = nv_r[1:0];
  wire [18:0] arr_a = addr_r[`SED_ARR_MSB:0];
  wire prot_hit =
    (bp == `SED_BP_NONE)    ? 1'b0 :
    (bp == `SED_BP_QUARTER) ? (arr_a >= `SED_QTR_BASE) :
    (bp == `SED_BP_HALF)    ? (arr_a >= `SED_HALF_BASE) :
                              1'b1;
  assign hw_protected = nv_r[`SED_NV_SWD] & ~wp_s;

  ////////////////////////////////////////////////////////////////////////////
  // End-of-frame execution.

  // Only whole bytes with no clock after the last one count.
  wire clean    = boundary_r & ~late_r;
  wire in_wait  = (state_r == sed_pkg::ST_WAIT);
  wire in_data  = (state_r == sed_pkg::ST_DATA);
  wire do_set   = cs_rise & in_wait & clean &
                  (cmd_r == sed_pkg::CMD_SET_WE);
  wire do_clr   = cs_rise & in_wait & clean &
                  (cmd_r == sed_pkg::CMD_CLR_WE);
  wire wr_ok    =
    ((cmd_r == sed_pkg::CMD_STAT_WR) & ~hw_protected) |
    ((cmd_r == sed_pkg::CMD_ARR_WR) & ~prot_hit) |
    (cmd_r == sed_pkg::CMD_ID_WR) | (cmd_r == sed_pkg::CMD_LOCK);
  wire do_write = cs_rise & in_data & clean & data_seen_r & wel_r &
                  wr_ok;
  wire push_ok  = byte_end & in_data & wel_r &
                  (cmd_r != sed_pkg::CMD_STAT_WR);

  sed_stream_if wd_if ();
  assign wd_if.valid = push_ok;
  assign wd_if.data  = byte_in;

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_r     <= sed_pkg::ST_IDLE;
      cmd_r       <= sed_pkg::CMD_NONE;
      shift_r     <= 7'h00;
      bit_cnt_r   <= 3'h0;
      byte_cnt_r  <= 2'h0;
      addr_r      <= 24'h000000;
      boundary_r  <= 1'b0;
      late_r      <= 1'b0;
      data_seen_r <= 1'b0;
      pushed_r    <= 1'b0;
      sr_new_r    <= `SED_NV_RESET;
      rx_overrun  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cs_fall) begin
        cmd_r       <= sed_pkg::CMD_NONE;
        bit_cnt_r   <= 3'h0;
        byte_cnt_r  <= 2'h0;
        boundary_r  <= 1'b0;
        late_r      <= 1'b0;
        data_seen_r <= 1'b0;
        pushed_r    <= 1'b0;
      end else if (rise_in) begin
        shift_r    <= byte_in[6:0];
        bit_cnt_r  <= bit_cnt_r + 3'h1;
        boundary_r <= (bit_cnt_r == `SED_BIT_LAST);
        if (in_wait) late_r <= 1'b1;
      end
      if (byte_end && state_r == sed_pkg::ST_OPCODE)
        cmd_r <= op_drop ? sed_pkg::CMD_NONE : op_cmd;
      if (byte_end && state_r == sed_pkg::ST_ADDR) begin
        addr_r     <= addr_in;
        byte_cnt_r <= byte_cnt_r + 2'h1;
        if (byte_cnt_r == `SED_ADDR_LAST) cmd_r <= addr_cmd;
      end
      if (byte_end && in_data) begin
        data_seen_r <= 1'b1;
        if (cmd_r == sed_pkg::CMD_STAT_WR)
          sr_new_r <= {byte_in[7], byte_in[3:2]};
      end
      if (push_ok) pushed_r <= 1'b1;
      // Sticky until the next frame; a lost byte is a master fault.
      if (push_ok && !wd_if.ready) rx_overrun <= 1'b1;
      else if (cs_fall)            rx_overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch, busy flag and non-volatile bits.

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      wel_r      <= 1'b0;
      wip_r      <= 1'b0;
      nv_r       <= `SED_NV_RESET;
      run_kind_r <= sed_pkg::CMD_NONE;
    end else begin
      if (do_set)                         wel_r <= 1'b1;
      else if (do_clr || (wip_r && wr_done)) wel_r <= 1'b0;
      if (do_write) begin
        wip_r      <= 1'b1;
        run_kind_r <= cmd_r;
      end else if (wr_done) begin
        wip_r <= 1'b0;
        if (wip_r && run_kind_r == sed_pkg::CMD_STAT_WR)
          nv_r <= sr_new_r;
      end
    end
  end

  assign status_byte = {nv_r[`SED_NV_SWD], `SED_SR_ZERO, nv_r[1:0],
                        wel_r, wip_r};

  ////////////////////////////////////////////////////////////////////////////
  // Status shift-out and command outputs.

  logic [7:0] so_sh_r;
  logic [2:0] so_cnt_r;
  wire        stat_go = byte_end & (state_r == sed_pkg::ST_OPCODE) &
                        (op_state == sed_pkg::ST_STATUS);

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      so_sh_r  <= 8'h00;
      so_cnt_r <= 3'h0;
      so       <= 1'b0;
    end else if (stat_go) begin
      so_sh_r  <= status_byte;
      so_cnt_r <= 3'h0;
    end else if (sck_fall && live && state_r == sed_pkg::ST_STATUS) begin
      so       <= so_sh_r[7];
      so_cnt_r <= so_cnt_r + 3'h1;
      // Reload with the current value so polling sees the busy flag fall.
      so_sh_r  <= (so_cnt_r == `SED_BIT_LAST) ? status_byte
                                              : {so_sh_r[6:0], 1'b0};
    end
  end

  assign so_oe = live & (state_r == sed_pkg::ST_STATUS);

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rd_req   <= 1'b0;
      rd_kind  <= sed_pkg::CMD_NONE;
      rd_addr  <= 24'h000000;
      wr_start <= 1'b0;
      wr_kind  <= sed_pkg::CMD_NONE;
      wr_addr  <= 24'h000000;
      wr_abort <= 1'b0;
    end else begin
      rd_req   <= addr_last & addr_is_rd;
      wr_start <= do_write;
      wr_abort <= cs_rise & pushed_r & ~do_write;
      if (addr_last && addr_is_rd) begin
        rd_kind <= addr_cmd;
        rd_addr <= mask_addr(addr_cmd, addr_in);
      end
      if (do_write) begin
        wr_kind <= cmd_r;
        wr_addr <= mask_addr(cmd_r, addr_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-data buffer.

  sed_fifo2 u_buf (
    .clk       (clk),
    .rst_n     (rst_ok_n),
    .in_if     (wd_if),
    .out_valid (wd_valid),
    .out_ready (wd_ready),
    .out_data  (wd_data)
  );

endmodule : sed_decoder

`default_nettype wire

//--- verification/sed_decoder_chk.sv
// Concurrent checks on the instruction decoder's top-level ports.
// Assumes it is bound to sed_decoder and sees nothing but its ports.
`timescale 1ns/100ps
`default_nettype none

module sed_decoder_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        so_oe,
  input wire logic        rd_req,
  input wire logic        wr_start,
  input var sed_pkg::sed_cmd_t wr_kind,
  input wire logic [23:0] wr_addr,
  input wire logic        wr_done,
  input wire logic [7:0]  status_byte,
  input wire logic        hw_protected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire logic [1:0] bp = status_byte[3:2];
  wire logic       arr_wr = wr_start && wr_kind == sed_pkg::CMD_ARR_WR;

  //////////////////////////////////////////////////////////////////////////
  busy_set_a: assert property (wr_start |-> ##[0:1] status_byte[0])
    else $error("busy flag did not follow a write start");
  latch_gate_a: assert property (wr_start |-> status_byte[1])
    else $error("write started with the latch clear");
  done_clear_a: assert property (status_byte[0] && wr_done
    |=> !status_byte[0] && !status_byte[1])
    else $error("write end did not clear busy and latch");
  latch_rise_a: assert property ($rose(status_byte[1])
    |-> cs_n && !status_byte[0])
    else $error("latch set while selected or busy");
  hwp_refuse_a: assert property (
    wr_start && wr_kind == sed_pkg::CMD_STAT_WR |-> !hw_protected)
    else $error("status write started while hardware protected");
  // Only the start address is judged, as the design checks no more.
  protect_range_a: assert property (arr_wr |-> bp == 2'h0 ||
    (bp == 2'h1 && wr_addr[18:0] < 19'h60000) ||
    (bp == 2'h2 && wr_addr[18:0] < 19'h40000))
    else $error("array write started inside a protected range");
  read_idle_a: assert property (rd_req |-> !status_byte[0])
    else $error("read accepted during a write cycle");
  so_release_a: assert property ($rose(cs_n) |-> ##5 !so_oe)
    else $error("serial output still enabled after deselect");

  cover property (arr_wr);
  cover property (rd_req);
  cover property ($fell(status_byte[0]));
  cover property (hw_protected);
endmodule : sed_decoder_chk

`default_nettype wire

//--- verification/sed_spi_master.sv
// Bus master model: drives chip select, serial clock and data in.
// Assumes clock idle low and a 320 ns serial clock period.
`timescale 1ns/100ps
`default_nettype none

module sed_spi_master (
  input wire logic clk,
  output logic     cs_n,
  output logic     sck,
  output logic     si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Frames start 1 ns after a clock edge, like every other bench input.
  // All later delays are whole clock periods, so that offset is kept.
  task automatic sel();
    @(posedge clk) #1 cs_n = 1'b0;
    #160;
  endtask : sel

  // Data out is taken at the end of the high phase, where it has settled.
  task automatic xfer(input logic [63:0] v, input int n,
                      output logic [63:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si = v[i];
      #160 sck = 1'b1;
      #160 r = {r[62:0], so};
      sck = 1'b0;
    end
  endtask : xfer

  // Chip select rises before any further clock rise, or writes are lost.
  task automatic desel();
    #80 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask : desel
endmodule : sed_spi_master

`default_nettype wire

//--- verification/spi_eeprom_instruction_decoder_bench.sv
// Self-checking bench for the instruction decoder with a master model.
// Assumes the core answers each write start after 300 clock cycles.
`timescale 1ns/100ps
`default_nettype none

`define SED_CHK(got, exp) begin check_count++; if ((got) !== (exp)) \
  begin mismatches++; $display("unexpected at %0t: got %h want %h", \
  $time, got, exp); end end

module spi_eeprom_instruction_decoder_bench;
  logic              clk, rst_n, wp_n, wr_done, wd_ready;
  logic              cs_n, sck, si, so, so_oe, rd_req, wr_start, wr_abort;
  logic              wd_valid, hw_protected, rx_overrun;
  logic [7:0]        wd_data, status_byte;
  logic [23:0]       rd_addr, wr_addr, ra, wa;
  logic [63:0]       rx;
  sed_pkg::sed_cmd_t rd_kind, wr_kind, rk, wk;
  int                mismatches, check_count, rd_cnt, wr_cnt, ab_cnt;

  typedef struct packed {
    logic [31:0]       cmd;
    logic [23:0]       ea;
    sed_pkg::sed_cmd_t k;
  } sed_row_t;
  sed_row_t rows [4] = '{
    '{32'h03FF1234, 24'h071234, sed_pkg::CMD_ARR_RD},
    '{32'h0307FFFF, 24'h07FFFF, sed_pkg::CMD_ARR_RD},
    '{32'h83FFFBFF, 24'h0001FF, sed_pkg::CMD_ID_RD},
    '{32'h83000400, 24'h000000, sed_pkg::CMD_LOCK_RD}
  };

  sed_decoder sed_decoder_inst (.clk, .rst_n, .cs_n, .sck, .si, .wp_n,
    .so, .so_oe, .rd_req, .rd_kind, .rd_addr, .wr_start, .wr_kind,
    .wr_addr, .wr_abort, .wr_done, .wd_valid, .wd_ready, .wd_data,
    .status_byte, .hw_protected, .rx_overrun);
  sed_spi_master sed_spi_master_inst (.clk, .cs_n, .sck, .si, .so);

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (rd_req) begin
    rk <= rd_kind;
    ra <= rd_addr;
    rd_cnt++;
  end

  always @(posedge clk) if (wr_abort) ab_cnt++;

  // Stand-in for the memory core: a fixed self-timed write length.
  initial forever begin
    @(posedge clk iff wr_start);
    wk = wr_kind;
    wa = wr_addr;
    wr_cnt++;
    repeat (300) @(posedge clk);
    #1 wr_done = 1'b1;
    @(posedge clk);
    #1 wr_done = 1'b0;
  end

  task automatic run(input logic [63:0] v, input int n);
    sed_spi_master_inst.sel();
    sed_spi_master_inst.xfer(v, n, rx);
    sed_spi_master_inst.desel();
  endtask : run

  task automatic idle();
    for (int i = 0; i < 400 && status_byte[0] !== 1'b0; i++)
      @(posedge clk);
    #1;
  endtask : idle

  task automatic wr(input logic [63:0] v, input int nb, input int inc);
    int n;
    n = wr_cnt;
    run(8'h06, 8);
    run(v, nb);
    `SED_CHK(wr_cnt, n + inc)
    idle();
  endtask : wr

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #3_000_000;
    mismatches++;
    test_done();
  end

  initial begin
    int n;
    rst_n = 1'b0;
    wp_n = 1'b1;
    wr_done = 1'b0;
    wd_ready = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    `SED_CHK(status_byte, 8'h00)
    foreach (rows[i]) begin
      n = rd_cnt;
      run(rows[i].cmd, 32);
      `SED_CHK(rd_cnt, n + 1)
      `SED_CHK(rk, rows[i].k)
      if (rows[i].k != sed_pkg::CMD_LOCK_RD)
        `SED_CHK(ra, rows[i].ea)
    end
    run({8'hFF, 8'h06}, 16);
    `SED_CHK(status_byte[1], 1'b0)
    sed_spi_master_inst.sel();
    sed_spi_master_inst.xfer(8'h06, 8, rx);
    #400;
    `SED_CHK(status_byte[1], 1'b0)
    sed_spi_master_inst.desel();
    `SED_CHK(status_byte[1], 1'b1)
    run({8'h05, 16'h0000}, 24);
    `SED_CHK(rx[15:0], 16'h0202)
    run(8'h04, 8);
    `SED_CHK(status_byte[1], 1'b0)
    n = wr_cnt;
    run({8'h01, 8'h8C}, 16);
    `SED_CHK(wr_cnt, n)
    run(8'h06, 8);
    run({8'h01, 7'h46}, 15);
    `SED_CHK(wr_cnt, n)
    run({8'h01, 8'h8C}, 16);
    `SED_CHK(wk, sed_pkg::CMD_STAT_WR)
    run({8'h05, 8'h00}, 16);
    `SED_CHK(rx[7:0], 8'h03)
    // An array read sent while the write cycle runs must be refused.
    n = rd_cnt;
    run(32'h03000000, 32);
    `SED_CHK(rd_cnt, n)
    idle();
    `SED_CHK(status_byte, 8'h8C)
    wr({8'h02, 24'h000010, 8'hA5}, 40, 0);
    @(posedge clk) #1 wp_n = 1'b0;
    repeat (4) @(posedge clk);
    `SED_CHK(hw_protected, 1'b1)
    wr({8'h01, 8'h00}, 16, 0);
    @(posedge clk) #1 wp_n = 1'b1;
    repeat (4) @(posedge clk);
    wr({8'h01, 8'h04}, 16, 1);
    `SED_CHK(status_byte, 8'h04)
    wr({8'h02, 24'hF5FFFF, 8'h11}, 40, 1);
    `SED_CHK(wk, sed_pkg::CMD_ARR_WR)
    `SED_CHK(wa[18:0], 19'h5FFFF)
    wr({8'h02, 24'h060000, 8'h22}, 40, 0);
    // Both refused array writes must have flushed their data byte.
    `SED_CHK(ab_cnt, 2)
    wr({8'h82, 24'hFFFB05, 8'h33}, 40, 1);
    `SED_CHK(wk, sed_pkg::CMD_ID_WR)
    `SED_CHK(wa[8:0], 9'h105)
    wr({8'h82, 24'h000400, 8'h44}, 40, 1);
    `SED_CHK(wk, sed_pkg::CMD_LOCK)
    // A stalled receiver: two bytes are held, the third is reported.
    @(posedge clk) #1 wd_ready = 1'b0;
    run(8'h06, 8);
    run({8'h02, 24'h000020, 24'hA1B2C3}, 56);
    `SED_CHK(rx_overrun, 1'b1)
    `SED_CHK(wd_data, 8'hA1)
    @(posedge clk) #1 wd_ready = 1'b1;
    @(posedge clk) #1;
    `SED_CHK(wd_data, 8'hB2)
    @(posedge clk) #1;
    `SED_CHK(wd_valid, 1'b0)
    idle();
    test_done();
  end
endmodule : spi_eeprom_instruction_decoder_bench

bind sed_decoder sed_decoder_chk sed_decoder_chk_inst (.clk, .rst_n,
  .cs_n, .so_oe, .rd_req, .wr_start, .wr_kind, .wr_addr, .wr_done,
  .status_byte, .hw_protected);

`default_nettype wire
